//--- design/dma_irq_cfg.svh
// Purpose: constants of the dma interrupt bookkeeping slice
// Assumes: word-aligned byte offsets on an 8-bit register address
// Notes: definitions only
`ifndef DMA_IRQ_CFG_SVH
`define DMA_IRQ_CFG_SVH

`define IRQ_NUM_CH 2
`define IRQ_ADDR_W 8
`define IRQ_DATA_W 32

// register offsets
`define IRQ_OFF_COMBINED 8'h00
`define IRQ_OFF_DONE_STAT 8'h04
`define IRQ_OFF_DONE_CLR 8'h08
`define IRQ_OFF_ERR_STAT 8'h0C

// field positions
`define IRQ_CH0_BIT 0
`define IRQ_CH1_BIT 1

// reset values
`define IRQ_FLAG_RST 1'b0
`define IRQ_RDATA_RST 32'h0000_0000

`endif

//--- design/dma_irq_pkg.sv
// Purpose: types shared by the interrupt slice and its channel cell
// Assumes: constants come from dma_irq_cfg.svh
// Notes: per-channel control and status travel as packed structs
`include "dma_irq_cfg.svh"

package dma_irq_pkg;

   // per-channel inputs to a flag cell
   typedef struct packed {
      logic tc_evt;
      logic tc_en;
      logic err_raw;
      logic err_en;
      logic done_clr;
   } chan_ctl_s;

   // per-channel state shown by a flag cell
   typedef struct packed {
      logic done_flag;
      logic err_flag;
      logic irq;
   } chan_stat_s;

   typedef logic [`IRQ_ADDR_W-1:0] reg_addr_t;
   typedef logic [`IRQ_DATA_W-1:0] reg_data_t;

endpackage : dma_irq_pkg

//--- design/irq_chan_flag.sv
// Purpose: one channel's transfer-done sticky flag and masked request
// Assumes: events and masks come from logic on i_sys_clk
// Notes: a done event beats a clear in the same cycle
`timescale 1ns/10ps
`include "dma_irq_cfg.svh"

module irq_chan_flag
   import dma_irq_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // channel control
   input wire chan_ctl_s i_ctl,
   // channel state
   output chan_stat_s o_stat
);

   logic done_raw_r;

   // set wins so a completion landing on the clear is kept
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         done_raw_r <= `IRQ_FLAG_RST;
      end else if (i_ctl.tc_evt) begin
         done_raw_r <= 1'b1;
      end else if (i_ctl.done_clr) begin
         done_raw_r <= 1'b0;
      end
   end

   always_comb begin
      o_stat.done_flag = done_raw_r & i_ctl.tc_en;
      o_stat.err_flag = i_ctl.err_raw & i_ctl.err_en;
      o_stat.irq = o_stat.done_flag | o_stat.err_flag;
   end

endmodule : irq_chan_flag

//--- design/dma_irq_status.sv
// Purpose: transfer-done clear and masked error status registers of a
//    two-channel dma controller, with per-channel interrupt requests
// Assumes: plain register port, read data one cycle after the strobe;
//    unit-side inputs come from logic on i_sys_clk, so no synchronisers
// Notes: the error raw state and its clear live elsewhere in the unit
// Operation
// - writing one at channel 1 clear bit drops channel 1 done flag
// - writing one at channel 0 clear bit drops channel 0 done flag
// - zero written to a clear bit leaves that flag unchanged
// - error status bit 1 reads channel 1 pending error request
// - error status bit 0 reads channel 0 pending error request
// - error status bits only show errors passed by their enable
// - done flags hold terminal-count events and show them only while their enable is set
// - channel request is raised by masked done or masked error
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "dma_irq_cfg.svh"

module dma_irq_status
   import dma_irq_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // register port
   input wire logic [`IRQ_ADDR_W-1:0] i_addr,
   input wire logic [`IRQ_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`IRQ_DATA_W-1:0] o_rdata,
   // channel events and masks
   input wire logic [`IRQ_NUM_CH-1:0] i_tc_evt,
   input wire logic [`IRQ_NUM_CH-1:0] i_tc_en,
   input wire logic [`IRQ_NUM_CH-1:0] i_err_raw,
   input wire logic [`IRQ_NUM_CH-1:0] i_err_en,
   // channel requests and flags
   output logic [`IRQ_NUM_CH-1:0] o_irq,
   output logic [`IRQ_NUM_CH-1:0] o_done_flag,
   output logic [`IRQ_NUM_CH-1:0] o_err_flag
);

   function automatic logic addr_hit(input reg_addr_t a, input reg_addr_t off);
      addr_hit = (a == off);
   endfunction : addr_hit

   // places the two channel bits in the low lanes, upper lanes zero
   function automatic reg_data_t pack_ch(input logic [`IRQ_NUM_CH-1:0] v);
      reg_data_t d;
      d = `IRQ_RDATA_RST;
      d[`IRQ_CH0_BIT] = v[0];
      d[`IRQ_CH1_BIT] = v[1];
      pack_ch = d;
   endfunction : pack_ch

   chan_ctl_s ctl [`IRQ_NUM_CH];
   chan_stat_s stat [`IRQ_NUM_CH];
   logic clr_wr;
   logic [`IRQ_NUM_CH-1:0] done_clr;
   logic [`IRQ_NUM_CH-1:0] done_flag;
   logic [`IRQ_NUM_CH-1:0] err_flag;
   logic [`IRQ_NUM_CH-1:0] irq;
   reg_data_t rdata_nxt;
   reg_data_t rdata_r;

   // only the clear offset is writable
   assign clr_wr = i_wr & addr_hit(i_addr, `IRQ_OFF_DONE_CLR);

   always_comb begin
      done_clr = '0;
      done_clr[1] = clr_wr & i_wdata[`IRQ_CH1_BIT];
      done_clr[0] = clr_wr & i_wdata[`IRQ_CH0_BIT];
   end

   genvar g;
   generate
      for (g = 0; g < `IRQ_NUM_CH; g++) begin : g_ch
         always_comb begin
            ctl[g].tc_evt = i_tc_evt[g];
            ctl[g].tc_en = i_tc_en[g];
            ctl[g].err_raw = i_err_raw[g];
            ctl[g].err_en = i_err_en[g];
            ctl[g].done_clr = done_clr[g];
         end

         irq_chan_flag u_flag (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_ctl(ctl[g]),
            .o_stat(stat[g])
         );

         assign done_flag[g] = stat[g].done_flag;
         assign err_flag[g] = stat[g].err_flag;
         assign irq[g] = stat[g].irq;
      end
   endgenerate

   always_comb begin
      rdata_nxt = `IRQ_RDATA_RST;
      if (i_rd) begin
         if (addr_hit(i_addr, `IRQ_OFF_COMBINED)) begin
            rdata_nxt = pack_ch(irq);
         end else if (addr_hit(i_addr, `IRQ_OFF_DONE_STAT)) begin
            rdata_nxt = pack_ch(done_flag);
         end else if (addr_hit(i_addr, `IRQ_OFF_ERR_STAT)) begin
            rdata_nxt = pack_ch(err_flag);
         end
         // clear register and holes read zero
      end
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_r <= `IRQ_RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_irq = irq;
   assign o_done_flag = done_flag;
   assign o_err_flag = err_flag;

endmodule : dma_irq_status

//--- bench/irq_status_assertions.sv
// Purpose: port checker of dma_irq_status
// Assumes: offsets of dma_irq_cfg.svh
// Notes: attached by bind
`timescale 1ns/10ps
`include "dma_irq_cfg.svh"
module irq_status_chk (
   // clock, reset and register port
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [`IRQ_ADDR_W-1:0] i_addr,
   input wire logic [`IRQ_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [`IRQ_DATA_W-1:0] o_rdata,
   // channel side
   input wire logic [`IRQ_NUM_CH-1:0] i_tc_evt,
   input wire logic [`IRQ_NUM_CH-1:0] i_tc_en,
   input wire logic [`IRQ_NUM_CH-1:0] i_err_raw,
   input wire logic [`IRQ_NUM_CH-1:0] i_err_en,
   input wire logic [`IRQ_NUM_CH-1:0] o_irq,
   input wire logic [`IRQ_NUM_CH-1:0] o_done_flag,
   input wire logic [`IRQ_NUM_CH-1:0] o_err_flag
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // an event in the clear cycle wins, so it is left out
   wire clr = i_wr && i_addr == `IRQ_OFF_DONE_CLR;
   sequence s_err_rd;
      i_rd && i_addr == `IRQ_OFF_ERR_STAT;
   endsequence
   clr1_a: assert property (clr && i_wdata[1] && !i_tc_evt[1] |=> !o_done_flag[1])
      else $error("ch1 clear missed");
   clr0_a: assert property (clr && i_wdata[0] && !i_tc_evt[0] |=> !o_done_flag[0])
      else $error("ch0 clear missed");
   keep_done_a: assert property (o_done_flag[0] && !(clr && i_wdata[0])
      |=> o_done_flag[0] || !i_tc_en[0]) else $error("done flag lost");
   err_read_a: assert property (s_err_rd |=> o_rdata == {30'h0, $past(o_err_flag)})
      else $error("error status read wrong");
   err_mask_a: assert property (o_err_flag == (i_err_raw & i_err_en))
      else $error("error mask wrong");
   done_set_a: assert property (i_tc_evt[1] |=> o_done_flag[1] == i_tc_en[1])
      else $error("done set wrong");
   done_set0_a: assert property (i_tc_evt[0] |=> o_done_flag[0] == i_tc_en[0])
      else $error("ch0 done set wrong");
   irq_or_a: assert property (o_irq == (o_done_flag | o_err_flag))
      else $error("request wrong");
   idle_zero_a: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("read data not zero");
endmodule : irq_status_chk
bind dma_irq_status irq_status_chk u_chk (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .i_tc_evt, .i_tc_en, .i_err_raw, .i_err_en, .o_irq, .o_done_flag,
   .o_err_flag);

//--- bench/dma_irq_status_test.sv
// Purpose: self-checking bench of dma_irq_status
// Assumes: offsets of dma_irq_cfg.svh
// Notes: checks go through register reads and direct looks at the flag and request outputs
`timescale 1ns/10ps
`include "dma_irq_cfg.svh"
module dma_irq_status_test;
   logic i_sys_clk, i_rst, i_wr, i_rd;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [1:0] i_tc_evt, i_tc_en, i_err_raw, i_err_en, o_irq, o_done_flag, o_err_flag;
   int fails, num_checks;
   // error raw, enable, expected status
   logic [5:0] rows [5] = '{6'h0C, 6'h3F, 6'h35, 6'h2E, 6'h30};
   dma_irq_status i_dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_tc_evt, .i_tc_en, .i_err_raw, .i_err_en, .o_irq, .o_done_flag, .o_err_flag);
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   // read passes the expected value in v
   task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge i_sys_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_sys_clk);
      {i_wr, i_rd} <= 2'h0;
      #1;
      if (!w) chk(o_rdata, v);
   endtask : acc
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      {i_wr, i_rd, i_addr, i_wdata, i_tc_evt, i_tc_en, i_err_raw, i_err_en} = '0;
      i_rst = 1'b1;
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      foreach (rows[k]) begin
         @(posedge i_sys_clk);
         {i_err_raw, i_err_en} <= rows[k][5:2];
         acc(1'b0, `IRQ_OFF_ERR_STAT, {30'h0, rows[k][1:0]});
         chk({30'h0, o_err_flag}, {30'h0, rows[k][1:0]});
         chk({30'h0, o_irq}, {30'h0, rows[k][1:0]});
      end
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h0);
      @(posedge i_sys_clk);
      {i_tc_en, i_tc_evt} <= 4'hF;
      @(posedge i_sys_clk);
      i_tc_evt <= 2'h0;
      acc(1'b1, `IRQ_OFF_DONE_CLR, 32'h0);
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h3);
      acc(1'b1, `IRQ_OFF_DONE_CLR, 32'h2);
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h1);
      @(posedge i_sys_clk);
      {i_err_raw, i_err_en} <= 4'hA;
      acc(1'b0, `IRQ_OFF_COMBINED, 32'h3);
      acc(1'b1, `IRQ_OFF_DONE_CLR, 32'h1);
      acc(1'b0, `IRQ_OFF_COMBINED, 32'h2);
      acc(1'b1, `IRQ_OFF_ERR_STAT, 32'h0);
      acc(1'b0, `IRQ_OFF_ERR_STAT, 32'h2);
      acc(1'b0, 8'h10, 32'h0);
      acc(1'b0, `IRQ_OFF_DONE_CLR, 32'h0);
      // event and clear of channel 0 in one cycle: the event is kept
      @(posedge i_sys_clk);
      {i_err_raw, i_err_en} <= 4'h0;
      i_tc_evt <= 2'h1;
      i_wr <= 1'b1;
      i_addr <= `IRQ_OFF_DONE_CLR;
      i_wdata <= 32'h1;
      @(posedge i_sys_clk);
      {i_wr, i_tc_evt} <= 3'h0;
      #1;
      chk({30'h0, o_done_flag}, 32'h1);
      chk({30'h0, o_irq}, 32'h1);
      chk({30'h0, o_err_flag}, 32'h0);
      // enable low hides the flag, raw state survives
      @(posedge i_sys_clk);
      i_tc_en <= 2'h0;
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h0);
      @(posedge i_sys_clk);
      i_tc_en <= 2'h3;
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h1);
      // reset in mid-run drops the sticky flag at once
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      @(posedge i_sys_clk);
      #1;
      chk({30'h0, o_done_flag}, 32'h0);
      chk(o_rdata, 32'h0);
      @(posedge i_sys_clk);
      i_rst <= 1'b0;
      acc(1'b0, `IRQ_OFF_DONE_STAT, 32'h0);
      test_done;
   end
   initial begin
      #10000;
      fails++;
      test_done;
   end
endmodule : dma_irq_status_test
